// file: common/pmpc_pkg.sv
// Constants shared by the PHY operating-mode controller and its helpers.
// Assumes a single 250 MHz core clock and APB access with 32-bit data.
package pmpc_pkg;
    // Clock rate and timing figures.
    localparam int CLK_MHZ = 250;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int WAKE_NS = 640;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SWRST_NS = 80;
    localparam int SWRST_CYC = (SWRST_NS * CLK_MHZ + 999) / 1000;
    localparam int MDIX_SLOT_US_DEF = 100;
    // Register indices; the byte address is four times the index.
    localparam int REG_CTRL_IDX = 0;
    localparam int REG_STAT_IDX = 1;
    localparam int REG_MODE_IDX = 17;
    localparam int REG_EXT2_IDX = 19;
    localparam logic [7:0] CTRL_ADDR = 8'(REG_CTRL_IDX * 4);
    localparam logic [7:0] STAT_ADDR = 8'(REG_STAT_IDX * 4);
    localparam logic [7:0] MODE_ADDR = 8'(REG_MODE_IDX * 4);
    localparam logic [7:0] EXT2_ADDR = 8'(REG_EXT2_IDX * 4);
    // Decoder one-hot positions.
    localparam int SEL_CTRL = 0;
    localparam int SEL_STAT = 1;
    localparam int SEL_MODE = 2;
    localparam int SEL_EXT2 = 3;
    // Control register fields.
    localparam int CTRL_DPX_BIT = 8;
    localparam int CTRL_PDN_BIT = 11;
    localparam int CTRL_AN_BIT = 12;
    localparam int CTRL_SPD_BIT = 13;
    localparam int CTRL_RST_BIT = 15;
    localparam logic [15:0] CTRL_RST_VAL = 16'h3000;
    // Extended control 2 fields.
    localparam int EXT2_SAVE100_BIT = 0;
    localparam int EXT2_SAVE10_BIT = 1;
    localparam int EXT2_XSWAP_BIT = 8;
    localparam int EXT2_XAUTO_BIT = 9;
    localparam logic [15:0] EXT2_RST_VAL = 16'h0200;
    // Status fields and latching defaults.
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_RFLT_BIT = 4;
    localparam logic LOW_DEF = 1'b0;
    localparam logic HIGH_DEF = 1'b0;
    localparam logic [7:0] MAX_DEF = 8'h00;
    localparam logic [7:0] MAX_SAT = 8'hff;
    // Synchronised pin vector positions.
    localparam int PIN_W = 6;
    localparam int PIN_RSTN = 0;
    localparam int PIN_AN = 1;
    localparam int PIN_CFG = 2;
    localparam int PIN_XOVER = 3;
    localparam int PIN_SPD = 4;
    localparam int PIN_DPX = 5;
    // Operating states.
    typedef enum logic [3:0] {
        ST_DOWN = 4'b0001,
        ST_WAKE = 4'b0010,
        ST_RUN = 4'b0100,
        ST_SWRST = 4'b1000
    } pmpc_state_t;
endpackage

// file: common/pmpc_mdix_if.sv
// Signals between the mode controller and the pair crossover controller.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface pmpc_mdix_if;
    logic active;
    logic auto_en;
    logic manual_swap;
    logic link_up;
    logic energy;
    logic tick;
    logic swap;
    logic settled;
    modport ctl (input active, auto_en, manual_swap, link_up, energy, tick,
                 output swap, settled);
    modport top (output active, auto_en, manual_swap, link_up, energy, tick,
                 input swap, settled);
endinterface

// file: hw/pmpc_sync.sv
// Two-stage synchroniser for a vector of slow pin levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/100ps
module pmpc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Levels.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_out[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule

// file: hw/pmpc_mdix.sv
// Automatic pair crossover: toggles the pair choice each slot without energy.
// Assumes a one-cycle tick every microsecond from the parent.
`timescale 1ns/100ps
module pmpc_mdix #(
    parameter int SLOT_US = pmpc_pkg::MDIX_SLOT_US_DEF
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Controller side.
    pmpc_mdix_if.ctl mx
);
    logic [15:0] slot_q;

    always_ff @(posedge core_clk) begin
        if (rst || !mx.active) begin
            slot_q <= 16'h0000;
            mx.swap <= 1'b0;
            mx.settled <= 1'b0;
        end else if (!mx.auto_en) begin
            slot_q <= 16'h0000;
            mx.swap <= mx.manual_swap;
            mx.settled <= 1'b1;
        end else if (mx.link_up || mx.energy) begin
            // Pair choice is kept once the far end is heard.
            slot_q <= 16'h0000;
            mx.settled <= 1'b1;
        end else begin
            mx.settled <= 1'b0;
            if (mx.tick) begin
                if (slot_q == 16'(SLOT_US - 1)) begin
                    slot_q <= 16'h0000;
                    mx.swap <= !mx.swap;
                end else begin
                    slot_q <= slot_q + 16'h0001;
                end
            end
        end
    end
endmodule

// file: hw/pmpc_top.sv
// Operating-mode and power control of a 10/100 twisted-pair PHY.
// Assumes APB on the core clock and line-side status from same-clock logic.
//
// Overview of operation
// - Power down on reset pin or bit.
// - Powered down: functions off, MAC outputs zero.
// - Powered down: line transmit outputs tristated.
// - Power bit keeps registers, clears latching bits.
// - Reset returns every register to default.
// - Bit 19.0 disables 100M blocks at 10M.
// - Bit 19.1 disables 10M blocks at 100M.
// - Source pin picks strap or bit 0.12.
// - Enabled negotiation picks best common mode.
// - 100M mode enables its block coders.
// - 10M mode enables Manchester coding.
// - 10M full duplex: no loopback, no SQE.
// - Full duplex: carrier on receive, no collision.
// - Half duplex: carrier either way, collision both.
// - Without link, crossover swaps the pairs.
// - Crossover disabled by pin or bit 19.9.
// - Crossover settles before negotiation proceeds.
// - Crossover enabled by default after reset.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module pmpc_top #(
    parameter int MDIX_SLOT_US = pmpc_pkg::MDIX_SLOT_US_DEF
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board pins.
    input wire logic hw_reset_pin_low,
    input wire logic autoneg_strap_pin,
    input wire logic config_source_select_pin,
    input wire logic crossover_enable_pin,
    input wire logic speed_strap_pin,
    input wire logic duplex_strap_pin,
    // Line and negotiation status.
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic link_up,
    input wire logic remote_fault,
    input wire logic rx_error,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic line_tx_bit,
    // MAC side.
    output logic crs,
    output logic col,
    output logic mac_outputs_en,
    // Line transmit pair.
    output logic line_tx_pos,
    output logic line_tx_pos_oe,
    output logic line_tx_neg,
    output logic line_tx_neg_oe,
    // Module enables.
    output logic en_100m_modules,
    output logic en_10m_modules,
    output logic coder_100m_en,
    output logic coder_10m_en,
    output logic loopback_en,
    output logic sqe_test_en,
    output logic autoneg_en,
    output logic autoneg_go,
    output logic mdix_swap,
    output logic powered_down
);
    logic [pmpc_pkg::PIN_W-1:0] pin_s;
    pmpc_pkg::pmpc_state_t state_q;
    logic [7:0] cnt_q;
    logic [15:0] ctrl_q;
    logic [15:0] ext2_q;
    logic link_lo_q;
    logic rflt_hi_q;
    logic [7:0] err_max_q;
    logic [7:0] tick_cnt_q;
    logic tick_q;
    logic [3:0] sel;
    logic apb_take;
    logic apb_done;
    logic wr_ctrl;
    logic wr_ext2;
    logic rd_stat;
    logic pd;
    logic run;
    logic swrst_done;
    logic regs_default;
    logic latch_init;
    logic hw_mode;
    logic an_enable;
    logic speed100;
    logic fd;
    logic xover_auto;
    pmpc_mdix_if mx ();

    pmpc_sync #(.W(pmpc_pkg::PIN_W)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({duplex_strap_pin, speed_strap_pin, crossover_enable_pin,
                   config_source_select_pin, autoneg_strap_pin, hw_reset_pin_low}),
        .sync_out(pin_s)
    );

    // One-hot register select; zero means an unmapped address.
    function automatic logic [3:0] reg_decode(input logic [7:0] a);
        logic [3:0] s;
        s = 4'h0;
        if (a == pmpc_pkg::CTRL_ADDR) begin
            s[pmpc_pkg::SEL_CTRL] = 1'b1;
        end else if (a == pmpc_pkg::STAT_ADDR) begin
            s[pmpc_pkg::SEL_STAT] = 1'b1;
        end else if (a == pmpc_pkg::MODE_ADDR) begin
            s[pmpc_pkg::SEL_MODE] = 1'b1;
        end else if (a == pmpc_pkg::EXT2_ADDR) begin
            s[pmpc_pkg::SEL_EXT2] = 1'b1;
        end
        return s;
    endfunction

    assign sel = reg_decode(paddr);
    assign apb_take = psel && penable && !pready;
    assign apb_done = psel && penable && pready;
    assign wr_ctrl = apb_done && pwrite && sel[pmpc_pkg::SEL_CTRL];
    assign wr_ext2 = apb_done && pwrite && sel[pmpc_pkg::SEL_EXT2];
    // Clearing at the edge that captures the read data leaves no cycle for an event to be lost.
    assign rd_stat = apb_take && !pwrite && sel[pmpc_pkg::SEL_STAT];

    assign pd = !pin_s[pmpc_pkg::PIN_RSTN] || ctrl_q[pmpc_pkg::CTRL_PDN_BIT];
    assign run = (state_q == pmpc_pkg::ST_RUN);
    assign swrst_done = (state_q == pmpc_pkg::ST_SWRST) && (cnt_q == 8'h00);
    // Pin reset and software reset both restore defaults; the pin holds power-down, software reset only for its countdown.
    assign regs_default = rst || !pin_s[pmpc_pkg::PIN_RSTN] || swrst_done;
    assign latch_init = regs_default || ctrl_q[pmpc_pkg::CTRL_PDN_BIT];

    // Configuration source is a board strap and is not expected to move.
    assign hw_mode = !pin_s[pmpc_pkg::PIN_CFG];
    assign an_enable = hw_mode ? pin_s[pmpc_pkg::PIN_AN] : ctrl_q[pmpc_pkg::CTRL_AN_BIT];
    always_comb begin
        if (an_enable) begin
            speed100 = an_speed_100;
            fd = an_full_duplex;
        end else if (hw_mode) begin
            speed100 = pin_s[pmpc_pkg::PIN_SPD];
            fd = pin_s[pmpc_pkg::PIN_DPX];
        end else begin
            speed100 = ctrl_q[pmpc_pkg::CTRL_SPD_BIT];
            fd = ctrl_q[pmpc_pkg::CTRL_DPX_BIT];
        end
    end

    // Power and reset sequencing.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= pmpc_pkg::ST_DOWN;
            cnt_q <= 8'h00;
        end else begin
            case (state_q)
                pmpc_pkg::ST_DOWN: begin
                    if (!pd) begin
                        state_q <= pmpc_pkg::ST_WAKE;
                        cnt_q <= 8'(pmpc_pkg::WAKE_CYC - 1);
                    end
                end
                pmpc_pkg::ST_WAKE: begin
                    if (pd) begin
                        state_q <= pmpc_pkg::ST_DOWN;
                    end else if (cnt_q == 8'h00) begin
                        state_q <= pmpc_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                pmpc_pkg::ST_RUN: begin
                    if (pd) begin
                        state_q <= pmpc_pkg::ST_DOWN;
                    end else if (ctrl_q[pmpc_pkg::CTRL_RST_BIT]) begin
                        state_q <= pmpc_pkg::ST_SWRST;
                        cnt_q <= 8'(pmpc_pkg::SWRST_CYC - 1);
                    end
                end
                pmpc_pkg::ST_SWRST: begin
                    if (!pin_s[pmpc_pkg::PIN_RSTN]) begin
                        state_q <= pmpc_pkg::ST_DOWN;
                    end else if (cnt_q == 8'h00) begin
                        state_q <= pmpc_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= pmpc_pkg::ST_DOWN;
                end
            endcase
        end
    end

    // Microsecond tick for the crossover slot timer.
    always_ff @(posedge core_clk) begin
        if (rst || tick_cnt_q == 8'(pmpc_pkg::TICK_CYC - 1)) begin
            tick_cnt_q <= 8'h00;
            tick_q <= !rst;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // Writable control registers.
    always_ff @(posedge core_clk) begin
        if (regs_default) begin
            ctrl_q <= pmpc_pkg::CTRL_RST_VAL;
            ext2_q <= pmpc_pkg::EXT2_RST_VAL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[15:0];
            end
            if (wr_ext2) begin
                ext2_q <= pwdata[15:0];
            end
        end
    end

    // Latching status; a new event in the read cycle wins over the clear.
    always_ff @(posedge core_clk) begin
        if (latch_init) begin
            link_lo_q <= pmpc_pkg::LOW_DEF;
            rflt_hi_q <= pmpc_pkg::HIGH_DEF;
            err_max_q <= pmpc_pkg::MAX_DEF;
        end else begin
            link_lo_q <= rd_stat ? link_up : (link_lo_q && link_up);
            rflt_hi_q <= rd_stat ? remote_fault : (rflt_hi_q || remote_fault);
            if (rd_stat) begin
                err_max_q <= {7'h00, rx_error};
            end else if (rx_error && err_max_q != pmpc_pkg::MAX_SAT) begin
                err_max_q <= err_max_q + 8'h01;
            end
        end
    end

    // APB answer one cycle into the access phase.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_take;
            pslverr <= apb_take && (sel == 4'h0);
            if (!apb_take || pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (sel[pmpc_pkg::SEL_CTRL]) begin
                prdata <= {16'h0000, ctrl_q};
            end else if (sel[pmpc_pkg::SEL_STAT]) begin
                prdata <= (32'(link_lo_q) << pmpc_pkg::STAT_LINK_BIT)
                          | (32'(rflt_hi_q) << pmpc_pkg::STAT_RFLT_BIT);
            end else if (sel[pmpc_pkg::SEL_MODE]) begin
                prdata <= {16'h0000, err_max_q, 2'b00, hw_mode, an_enable,
                           mdix_swap, fd, speed100, powered_down};
            end else if (sel[pmpc_pkg::SEL_EXT2]) begin
                prdata <= {16'h0000, ext2_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Crossover controller hookup.
    assign xover_auto = ext2_q[pmpc_pkg::EXT2_XAUTO_BIT] && pin_s[pmpc_pkg::PIN_XOVER];
    assign mx.active = run;
    assign mx.auto_en = xover_auto;
    assign mx.manual_swap = ext2_q[pmpc_pkg::EXT2_XSWAP_BIT];
    assign mx.link_up = link_up;
    assign mx.energy = rx_active;
    assign mx.tick = tick_q;

    pmpc_mdix #(.SLOT_US(MDIX_SLOT_US)) u_mdix (
        .core_clk(core_clk),
        .rst(rst),
        .mx(mx)
    );

    // Registered outputs; everything but management and powered_down falls quiet unless running.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            crs <= 1'b0;
            col <= 1'b0;
            mac_outputs_en <= 1'b0;
            line_tx_pos <= 1'b0;
            line_tx_neg <= 1'b0;
            line_tx_pos_oe <= 1'b0;
            line_tx_neg_oe <= 1'b0;
            en_100m_modules <= 1'b0;
            en_10m_modules <= 1'b0;
            coder_100m_en <= 1'b0;
            coder_10m_en <= 1'b0;
            loopback_en <= 1'b0;
            sqe_test_en <= 1'b0;
            autoneg_en <= 1'b0;
            autoneg_go <= 1'b0;
            mdix_swap <= 1'b0;
            powered_down <= 1'b1;
        end else begin
            crs <= run && (rx_active || (!fd && tx_active));
            col <= run && !fd && tx_active && rx_active;
            mac_outputs_en <= run;
            line_tx_pos <= run && line_tx_bit;
            line_tx_neg <= run && !line_tx_bit;
            line_tx_pos_oe <= run;
            line_tx_neg_oe <= run;
            en_100m_modules <= run && (speed100 || !ext2_q[pmpc_pkg::EXT2_SAVE100_BIT]);
            en_10m_modules <= run && (!speed100 || !ext2_q[pmpc_pkg::EXT2_SAVE10_BIT]);
            coder_100m_en <= run && speed100;
            coder_10m_en <= run && !speed100;
            loopback_en <= run && !speed100 && !fd;
            sqe_test_en <= run && !speed100 && !fd;
            autoneg_en <= run && an_enable;
            autoneg_go <= run && an_enable && (mx.settled || !xover_auto);
            mdix_swap <= mx.swap;
            powered_down <= !run;
        end
    end

    property p_tx_tristate;
        @(posedge core_clk) disable iff (rst) pd |-> ##2 (!line_tx_pos_oe && !line_tx_neg_oe);
    endproperty
    a_tx_tristate: assert property (p_tx_tristate) else $error("Line outputs driven in power-down.");

    property p_mac_quiet;
        @(posedge core_clk) disable iff (rst) pd |-> ##2 (!crs && !col && !mac_outputs_en);
    endproperty
    a_mac_quiet: assert property (p_mac_quiet) else $error("MAC outputs active in power-down.");

    property p_fd_carrier;
        @(posedge core_clk) disable iff (rst)
            (run && fd && tx_active && !rx_active) |=> (!crs && !col);
    endproperty
    a_fd_carrier: assert property (p_fd_carrier) else $error("Full duplex carrier on transmit.");

    property p_hd_collision;
        @(posedge core_clk) disable iff (rst)
            (run && !fd && tx_active && rx_active) |=> (crs && col);
    endproperty
    a_hd_collision: assert property (p_hd_collision) else $error("Half duplex collision missed.");

    property p_save100;
        @(posedge core_clk) disable iff (rst)
            (run && !speed100) |=> (en_100m_modules == !$past(ext2_q[pmpc_pkg::EXT2_SAVE100_BIT]));
    endproperty
    a_save100: assert property (p_save100) else $error("100M module enable wrong at 10M.");

    property p_save10;
        @(posedge core_clk) disable iff (rst)
            (run && speed100) |=> (en_10m_modules == !$past(ext2_q[pmpc_pkg::EXT2_SAVE10_BIT]));
    endproperty
    a_save10: assert property (p_save10) else $error("10M module enable wrong at 100M.");

    property p_fd10_noloop;
        @(posedge core_clk) disable iff (rst)
            (run && !speed100 && fd) |=> (!loopback_en && !sqe_test_en);
    endproperty
    a_fd10_noloop: assert property (p_fd10_noloop) else $error("Loopback or SQE in 10M full duplex.");

    property p_latch_clear;
        @(posedge core_clk) disable iff (rst)
            ctrl_q[pmpc_pkg::CTRL_PDN_BIT] |=> (link_lo_q == pmpc_pkg::LOW_DEF
                && rflt_hi_q == pmpc_pkg::HIGH_DEF && err_max_q == pmpc_pkg::MAX_DEF);
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("Latching bits kept in power-down.");

    property p_an_strap;
        @(posedge core_clk) disable iff (rst)
            (run && hw_mode) |=> (autoneg_en == $past(pin_s[pmpc_pkg::PIN_AN]));
    endproperty
    a_an_strap: assert property (p_an_strap) else $error("Strap not steering negotiation.");

    property p_wake;
        @(posedge core_clk) disable iff (rst)
            ($fell(ctrl_q[pmpc_pkg::CTRL_PDN_BIT]) && pin_s[pmpc_pkg::PIN_RSTN])
                |-> ##[1:170] (mac_outputs_en || pd);
    endproperty
    a_wake: assert property (p_wake) else $error("No resume after power bit cleared.");
endmodule

// file: test/pmpc_mac_model.sv
// MAC-side stand-in that drives transmit and receive activity on command.
// Assumes the core clock; every level changes just after a rising edge.
`timescale 1ns/100ps
module pmpc_mac_model (
    // Clock.
    input wire logic core_clk,
    // Bench command: bit 0 transmit, bit 1 receive.
    input wire logic [1:0] act_cmd,
    // Activity towards the block.
    output logic tx_active,
    output logic rx_active,
    output logic line_tx_bit
);
    logic tog_q = 1'b0;
    // The serial bit changes every cycle so a stuck line output is seen.
    always_ff @(posedge core_clk) begin
        tx_active <= act_cmd[0];
        rx_active <= act_cmd[1];
        tog_q <= ~tog_q;
    end
    assign line_tx_bit = tog_q;
endmodule

// file: test/pmpc_top_bench.sv
// Self-checking bench for the operating-mode and power controller.
// Assumes the package is compiled first and a short crossover slot.
`timescale 1ns/100ps
module pmpc_top_bench;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, rnd = 32'h0000_00ef;
    logic pready, pslverr, e, rpin = 1'b1, ans = 1'b0, cfg = 1'b1, xpin = 1'b1;
    logic spd_s = 1'b0, dpx_s = 1'b0, link = 1'b0, rflt = 1'b0, rxerr = 1'b0;
    logic an_s100 = 1'b0, an_fd = 1'b0, tx, rx, tb, crs, col, mac_en, tp, tpoe, tn, tnoe;
    logic e100, e10, c100, c10, lb, sqe, an_en, an_go, swap, pd;
    logic [1:0] act = 2'b00;
    int error_cnt = 0, checked = 0, spd, fd, sv, n;
    always #2 core_clk = ~core_clk;
    pmpc_mac_model pmpc_mac_model_i (.core_clk(core_clk), .act_cmd(act), .tx_active(tx),
        .rx_active(rx), .line_tx_bit(tb));
    pmpc_top #(.MDIX_SLOT_US(2)) pmpc_top_i (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_reset_pin_low(rpin), .autoneg_strap_pin(ans),
        .config_source_select_pin(cfg), .crossover_enable_pin(xpin), .speed_strap_pin(spd_s),
        .duplex_strap_pin(dpx_s), .tx_active(tx), .rx_active(rx), .link_up(link),
        .remote_fault(rflt), .rx_error(rxerr), .an_speed_100(an_s100),
        .an_full_duplex(an_fd), .line_tx_bit(tb), .crs(crs), .col(col), .mac_outputs_en(mac_en),
        .line_tx_pos(tp), .line_tx_pos_oe(tpoe), .line_tx_neg(tn), .line_tx_neg_oe(tnoe),
        .en_100m_modules(e100), .en_10m_modules(e10), .coder_100m_en(c100),
        .coder_10m_en(c10), .loopback_en(lb), .sqe_test_en(sqe), .autoneg_en(an_en),
        .autoneg_go(an_go), .mdix_swap(swap), .powered_down(pd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic complete_run();
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic chkb(input string nm, input logic x, input logic g);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic wait_pd(input logic want);
        for (n = 0; n < 500 && pd !== want; n++) @(posedge core_clk);
        if (n == 500) begin
            error_cnt++;
            complete_run();
        end
        chkb("powered_down", want, pd);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, pmpc_pkg::CTRL_ADDR, 0);
        chk("ctrl", 32'h0000_3000, q);
        apb(0, pmpc_pkg::EXT2_ADDR, 0);
        chk("ext2", 32'h0000_0200, q);
        apb(0, 8'h08, 0);
        chkb("slverr", 1'b1, e);
        wait_pd(0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            spd = m / 2;
            fd = m % 2;
            sv = m % 2;
            apb(1, pmpc_pkg::CTRL_ADDR, 32'((spd << 13) | (fd << 8)));
            apb(1, pmpc_pkg::EXT2_ADDR, 32'(32'h0200 | (sv * 3)));
            for (int j = 0; j < 6; j++) begin
                act <= rnd[1:0];
                rnd = lfsr(rnd);
                repeat (4) @(posedge core_clk);
                chkb("crs", act[1] | (fd == 0 && act[0]), crs);
                chkb("col", fd == 0 && act == 2'b11, col);
            end
            chkb("coder100", spd == 1, c100);
            chkb("coder10", spd == 0, c10);
            chkb("loopback", spd == 0 && fd == 0, lb);
            chkb("sqe", spd == 0 && fd == 0, sqe);
            chkb("en100", spd == 1 || sv == 0, e100);
            chkb("en10", spd == 0 || sv == 0, e10);
        end
        $display("test modes done");
        repeat (3) begin
            rxerr <= 1'b1;
            @(posedge core_clk);
            rxerr <= 1'b0;
            @(posedge core_clk);
        end
        apb(0, pmpc_pkg::MODE_ADDR, 0);
        chk("errcnt", 32'h0000_0003, {24'h0, q[15:8]});
        rflt <= 1'b1;
        apb(0, pmpc_pkg::STAT_ADDR, 0);
        chk("stat", 32'h0000_0010, q);
        apb(1, pmpc_pkg::EXT2_ADDR, 32'h0000_0201);
        apb(1, pmpc_pkg::CTRL_ADDR, 32'h0000_2900);
        act <= 2'b11;
        wait_pd(1);
        repeat (3) @(posedge core_clk);
        chk("mac_side", 32'h0, {29'h0, crs, col, mac_en});
        chk("line_oe", 32'h0, {30'h0, tpoe, tnoe});
        apb(0, pmpc_pkg::CTRL_ADDR, 0);
        chk("ctrl_kept", 32'h0000_2900, q);
        apb(0, pmpc_pkg::EXT2_ADDR, 0);
        chk("ext2_kept", 32'h0000_0201, q);
        apb(0, pmpc_pkg::MODE_ADDR, 0);
        chk("errcnt_pd", 32'h0, {24'h0, q[15:8]});
        apb(0, pmpc_pkg::STAT_ADDR, 0);
        chk("stat_pd", 32'h0, q);
        rflt <= 1'b0;
        apb(1, pmpc_pkg::CTRL_ADDR, 32'h0000_2100);
        wait_pd(0);
        repeat (3) @(posedge core_clk);
        chk("line_run", 32'h0000_0007, {29'h0, tpoe, tnoe, tp ^ tn});
        $display("test power down done");
        for (int s = 0; s < 4; s++) begin
            cfg <= s[1];
            ans <= s[0];
            apb(1, pmpc_pkg::CTRL_ADDR, 32'(32'h2000 | ((1 - (s % 2)) << 12)));
            repeat (6) @(posedge core_clk);
            chkb("an_en", s[1] ? !s[0] : s[0], an_en);
        end
        $display("test negotiation source done");
        act <= 2'b00;
        an_s100 <= 1'b1;
        apb(1, pmpc_pkg::CTRL_ADDR, 32'h0000_3000);
        apb(1, pmpc_pkg::EXT2_ADDR, 32'h0000_0200);
        e = swap;
        for (n = 0; n < 700 && swap === e; n++) @(posedge core_clk);
        chkb("swap_moves", !e, swap);
        if (n == 700)
            complete_run();
        chkb("an_wait", 1'b0, an_go);
        link <= 1'b1;
        repeat (6) @(posedge core_clk);
        chkb("an_go", 1'b1, an_go);
        chkb("an_speed", 1'b1, c100);
        xpin <= 1'b0;
        apb(1, pmpc_pkg::EXT2_ADDR, 32'h0000_0100);
        repeat (6) @(posedge core_clk);
        chkb("swap_manual", 1'b1, swap);
        $display("test crossover done");
        apb(1, pmpc_pkg::CTRL_ADDR, 32'h0000_a100);
        wait_pd(1);
        wait_pd(0);
        apb(0, pmpc_pkg::CTRL_ADDR, 0);
        chk("ctrl_sw", 32'h0000_3000, q);
        apb(0, pmpc_pkg::EXT2_ADDR, 0);
        chk("ext2_sw", 32'h0000_0200, q);
        rpin <= 1'b0;
        wait_pd(1);
        apb(0, pmpc_pkg::CTRL_ADDR, 0);
        chk("ctrl_hw", 32'h0000_3000, q);
        apb(0, pmpc_pkg::EXT2_ADDR, 0);
        chk("ext2_hw", 32'h0000_0200, q);
        rpin <= 1'b1;
        wait_pd(0);
        $display("test pin reset done");
        complete_run();
    end
endmodule
